/* rtl/wdtta_osc_counter.sv */
module wdtta_osc_counter #(
  parameter int unsigned TIMEOUT_BASE = wdtta_pkg::TIMEOUT_BASE_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control side
  wdtta_osc_if.cnt osc
);
  logic [wdtta_pkg::CNT_W-1:0] cnt_q;
  logic [wdtta_pkg::CNT_W-1:0] limit;
  logic ack_q;
  logic expire_q;

  // Base doubles per select step; the select is only looked at on an oscillator tick
  assign limit = wdtta_pkg::CNT_W'(TIMEOUT_BASE) << osc.tsel;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (osc.tick) begin
      if (!osc.enable) begin
        cnt_q <= '0;
      end else if (osc.restart_req) begin
        cnt_q <= '0;
      end else if (cnt_q >= limit - wdtta_pkg::CNT_W'(1)) begin
        // At or past the end, so lowering the select mid-count still expires instead of wrapping
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + wdtta_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      ack_q <= osc.tick && osc.restart_req;
      expire_q <= osc.tick && osc.enable && !osc.restart_req
                  && (cnt_q >= limit - wdtta_pkg::CNT_W'(1));
    end
  end

  assign osc.restart_ack = ack_q;
  assign osc.expire = expire_q;
endmodule

/* rtl/wdtta_top.sv */
// Our own choices: the register addresses and the address-and-strobe port.
module wdtta_top #(
  parameter int unsigned TIMEOUT_BASE = wdtta_pkg::TIMEOUT_BASE_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por,
  // Strap and core
  input wire logic always_on_fuse,
  input wire logic restart_instruction,
  // Register port
  input wire logic [wdtta_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdtta_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdtta_pkg::DATA_W-1:0] reg_rdata,
  // Reset request and interrupt
  output logic wdt_reset_pulse,
  output logic irq
);
  wdtta_osc_if osc ();

  wdtta_pkg::wdtta_lock_t lock_q;
  logic [wdtta_pkg::UNLOCK_W-1:0] unlock_cnt_q;
  logic enable_q;
  logic [wdtta_pkg::TSEL_W-1:0] tsel_q;
  logic fuse_meta_q;
  logic fuse_q;
  logic enable_eff;
  logic [wdtta_pkg::DIV_W-1:0] div_q;
  logic tick_q;
  logic restart_pend_q;
  logic wdt_flag_q;
  logic [wdtta_pkg::IRQ_W-1:0] irq_stat_q;
  logic [wdtta_pkg::IRQ_W-1:0] irq_mask_q;
  logic [wdtta_pkg::DATA_W-1:0] rdata_q;
  logic reset_pulse_q;
  logic irq_q;
  logic ctrl_wr;
  logic cause_wr;
  logic mask_wr;
  logic stat_rd;
  logic [wdtta_pkg::TSEL_W-1:0] wr_tsel;
  logic open_req;
  logic refused;
  logic [wdtta_pkg::IRQ_W-1:0] irq_set;

  // Register address decode, shared by read and write paths
  function automatic logic hit(input logic [wdtta_pkg::ADDR_W-1:0] addr,
                               input logic [wdtta_pkg::ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [wdtta_pkg::DATA_W-1:0] read_mux(
    input logic [wdtta_pkg::ADDR_W-1:0] addr,
    input logic [wdtta_pkg::DATA_W-1:0] ctrl_v,
    input logic [wdtta_pkg::DATA_W-1:0] cause_v,
    input logic [wdtta_pkg::DATA_W-1:0] stat_v,
    input logic [wdtta_pkg::DATA_W-1:0] mask_v);
    if (hit(addr, wdtta_pkg::OFS_CONTROL)) begin
      read_mux = ctrl_v;
    end else if (hit(addr, wdtta_pkg::OFS_CAUSE)) begin
      read_mux = cause_v;
    end else if (hit(addr, wdtta_pkg::OFS_IRQ_STAT)) begin
      read_mux = stat_v;
    end else if (hit(addr, wdtta_pkg::OFS_IRQ_MASK)) begin
      read_mux = mask_v;
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  assign ctrl_wr = reg_wr && hit(reg_addr, wdtta_pkg::OFS_CONTROL);
  assign cause_wr = reg_wr && hit(reg_addr, wdtta_pkg::OFS_CAUSE);
  assign mask_wr = reg_wr && hit(reg_addr, wdtta_pkg::OFS_IRQ_MASK);
  assign stat_rd = reg_rd && hit(reg_addr, wdtta_pkg::OFS_IRQ_STAT);
  assign wr_tsel = reg_wdata[wdtta_pkg::TSEL_LSB +: wdtta_pkg::TSEL_W];
  assign open_req = reg_wdata[wdtta_pkg::BIT_UNLOCK] && reg_wdata[wdtta_pkg::BIT_ENABLE];

  // Fuse is a strap: caught while reset is held so it cannot change under a running count
  // The fuse pin is outside the clock domain, so it passes two flops first
  always_ff @(posedge clk) begin
    fuse_meta_q <= always_on_fuse;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fuse_q <= fuse_meta_q;
    end
  end

  assign enable_eff = fuse_q || enable_q;

  // Unlock window and protected control fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_q <= wdtta_pkg::LOCKED;
      unlock_cnt_q <= '0;
      enable_q <= 1'b0;
      tsel_q <= wdtta_pkg::TSEL_RST;
    end else if (ctrl_wr && open_req) begin
      // Opening write also enables; its select bits are ignored
      lock_q <= wdtta_pkg::OPEN;
      unlock_cnt_q <= wdtta_pkg::UNLOCK_LAST;
      enable_q <= 1'b1;
    end else if (ctrl_wr && lock_q == wdtta_pkg::OPEN) begin
      // Write inside the window wins over the hardware close in the same cycle
      lock_q <= wdtta_pkg::LOCKED;
      enable_q <= reg_wdata[wdtta_pkg::BIT_ENABLE];
      tsel_q <= wr_tsel;
    end else begin
      if (ctrl_wr && reg_wdata[wdtta_pkg::BIT_ENABLE]) begin
        enable_q <= 1'b1;
      end
      if (lock_q == wdtta_pkg::OPEN) begin
        if (unlock_cnt_q == '0) begin
          lock_q <= wdtta_pkg::LOCKED;
        end else begin
          unlock_cnt_q <= unlock_cnt_q - wdtta_pkg::UNLOCK_W'(1);
        end
      end
    end
  end

  // A write outside the window that tries to drop enable or move the select
  assign refused = ctrl_wr && !open_req && lock_q == wdtta_pkg::LOCKED
                   && ((enable_eff && !reg_wdata[wdtta_pkg::BIT_ENABLE])
                       || (wr_tsel != tsel_q));

  // Oscillator tick: a divider stands in for the separate oscillator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      if (div_q == wdtta_pkg::DIV_W'(wdtta_pkg::OSC_DIV - 1)) begin
        div_q <= '0;
        tick_q <= 1'b1;
      end else begin
        div_q <= div_q + wdtta_pkg::DIV_W'(1);
        tick_q <= 1'b0;
      end
    end
  end

  // Restart is held until the counter side takes it on a tick, so none is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_pend_q <= 1'b0;
    end else if (restart_instruction) begin
      restart_pend_q <= 1'b1;
    end else if (osc.restart_ack) begin
      restart_pend_q <= 1'b0;
    end
  end

  assign osc.tick = tick_q;
  assign osc.enable = enable_eff;
  assign osc.tsel = tsel_q;
  assign osc.restart_req = restart_pend_q;

  wdtta_osc_counter #(
    .TIMEOUT_BASE(TIMEOUT_BASE)
  ) u_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc(osc)
  );

  // One-cycle chip reset request on expiry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_pulse_q <= 1'b0;
    end else begin
      reset_pulse_q <= osc.expire;
    end
  end

  // Cause flag survives the chip reset it caused; only power-on clears it by itself
  always_ff @(posedge clk) begin
    if (por) begin
      wdt_flag_q <= 1'b0;
    end else if (osc.expire) begin
      wdt_flag_q <= 1'b1;
    end else if (cause_wr && !reg_wdata[wdtta_pkg::BIT_WDT_FLAG]) begin
      wdt_flag_q <= 1'b0;
    end
  end

  // Interrupt status: sticky, cleared by a read, a new event wins over that read
  always_comb begin
    irq_set = '0;
    irq_set[wdtta_pkg::IRQ_TIMEOUT] = osc.expire;
    irq_set[wdtta_pkg::IRQ_REFUSED] = refused;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
    end else if (stat_rd) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_q <= wdtta_pkg::IRQ_MASK_RST;
    end else if (mask_wr) begin
      irq_mask_q <= reg_wdata[wdtta_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= read_mux(reg_addr,
        {3'h0, lock_q == wdtta_pkg::OPEN, enable_eff, tsel_q},
        {4'h0, wdt_flag_q, 3'h0},
        {6'h00, irq_stat_q},
        {6'h00, irq_mask_q});
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign wdt_reset_pulse = reset_pulse_q;
  assign irq = irq_q;
endmodule

/* shared/wdtta_osc_if.sv */
interface wdtta_osc_if;
  logic tick;
  logic enable;
  logic [wdtta_pkg::TSEL_W-1:0] tsel;
  logic restart_req;
  logic restart_ack;
  logic expire;

  modport ctl (
    output tick,
    output enable,
    output tsel,
    output restart_req,
    input restart_ack,
    input expire
  );

  modport cnt (
    input tick,
    input enable,
    input tsel,
    input restart_req,
    output restart_ack,
    output expire
  );
endinterface

/* shared/wdtta_pkg.sv */
package wdtta_pkg;
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;

  // watchdog_control fields
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_ENABLE = 3;
  localparam int TSEL_LSB = 0;
  localparam int TSEL_W = 3;
  localparam logic [TSEL_W-1:0] TSEL_RST = 3'h0;

  // reset_cause_status fields
  localparam int BIT_WDT_FLAG = 3;

  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_REFUSED = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 5;
  localparam int UNLOCK_CYCLES = 4;
  localparam int UNLOCK_W = 2;
  localparam logic [UNLOCK_W-1:0] UNLOCK_LAST = UNLOCK_W'(UNLOCK_CYCLES - 1);
  localparam int unsigned TIMEOUT_BASE_DEF = 16384;
  localparam int CNT_W = 22;

  typedef enum logic {
    LOCKED = 1'b0,
    OPEN = 1'b1
  } wdtta_lock_t;
endpackage

/* verif/wdtta_props.sv */
module wdtta_props #(
  parameter int unsigned TIMEOUT_BASE = wdtta_pkg::TIMEOUT_BASE_DEF
) (
  // Clock, reset, strap and restart
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic always_on_fuse,
  input wire logic restart_instruction,
  // Register port and reset request
  input wire logic [wdtta_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdtta_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [wdtta_pkg::DATA_W-1:0] reg_rdata,
  input wire logic wdt_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_GAP = (TIMEOUT_BASE - 1) * 25;
  logic rd_ctl_q;
  logic rd_cause_q;
  logic en_seen_q;
  int since_q;
  wire logic ctl_rd = reg_rd && reg_addr == wdtta_pkg::OFS_CONTROL;
  wire logic ctl_wr = reg_wr && reg_addr == wdtta_pkg::OFS_CONTROL;
  wire logic open_wr = ctl_wr && reg_wdata[wdtta_pkg::BIT_UNLOCK] && reg_wdata[wdtta_pkg::BIT_ENABLE];
  always_ff @(posedge clk) begin
    rd_ctl_q <= ctl_rd;
    rd_cause_q <= reg_rd && reg_addr == wdtta_pkg::OFS_CAUSE;
  end
  // Counts from the last restart, an upper bound on the real count since disabling also clears it
  always_ff @(posedge clk) begin
    if (sys_rst || restart_instruction) since_q <= 0;
    else if (since_q < MIN_GAP) since_q <= since_q + 1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) en_seen_q <= always_on_fuse;
    else if (ctl_wr && reg_wdata[wdtta_pkg::BIT_ENABLE]) en_seen_q <= 1'b1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ctl_reserved_a: assert property (rd_ctl_q |-> reg_rdata[7:5] == 3'h0)
    else $error("control reserved bits not zero");
  pulse_single_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse longer than one cycle");
  unlock_shown_a: assert property (open_wr ##1 ctl_rd |=> reg_rdata[4])
    else $error("unlock bit not shown after opening write");
  unlock_clear_a: assert property (open_wr ##1 !reg_wr [*4] ##1 ctl_rd |=> !reg_rdata[4])
    else $error("unlock bit not cleared after four cycles");
  no_early_a: assert property (wdt_reset_pulse |-> since_q >= MIN_GAP)
    else $error("reset pulse too soon after restart");
  // Read strobe two cycles after the pulse shows up in rd_cause_q one cycle later; a write just after could clear
  cause_flag_a: assert property (wdt_reset_pulse ##1 !reg_wr ##2 rd_cause_q |-> reg_rdata[3])
    else $error("cause flag not set after timeout");
  fuse_enable_a: assert property (rd_ctl_q && always_on_fuse |-> reg_rdata[3])
    else $error("enable not read as one with fuse");
  quiet_off_a: assert property (!en_seen_q |-> !wdt_reset_pulse)
    else $error("reset pulse while never enabled");
endmodule

bind wdtta_top wdtta_props #(.TIMEOUT_BASE(TIMEOUT_BASE)) wdtta_props_inst (.clk(clk), .sys_rst(sys_rst),
  .always_on_fuse(always_on_fuse), .restart_instruction(restart_instruction), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wdt_reset_pulse(wdt_reset_pulse));

/* verif/wdtta_tb.sv */
module wdtta_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TB = 4;
  localparam logic [3:0] CTL = wdtta_pkg::OFS_CONTROL;
  localparam logic [3:0] CAU = wdtta_pkg::OFS_CAUSE;
  logic clk, sys_rst, por, always_on_fuse, restart_instruction, reg_wr, reg_rd, wdt_reset_pulse, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int bad_count, n_tests, seed, n, lim;
  wdtta_top #(.TIMEOUT_BASE(TB)) wdtta_top_inst (.clk(clk), .sys_rst(sys_rst), .por(por),
    .always_on_fuse(always_on_fuse), .restart_instruction(restart_instruction), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wdt_reset_pulse(wdt_reset_pulse), .irq(irq));
  // Expected timeout in oscillator ticks for a select code
  function automatic int ticks_for(int code);
    return TB << code;
  endfunction
  // Expected control read value
  function automatic logic [7:0] ctl_val(logic unl, logic en, logic [2:0] ts);
    return {3'h0, unl, en, ts};
  endfunction
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
  endtask
  task automatic idle(int k);
    repeat (k) begin
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      restart_instruction <= 1'b0;
    end
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp, string name);
    bus(1'b0, a, 8'h00);
    idle(1);
    #1;
    chk(name, exp, reg_rdata);
  endtask
  task automatic rst(logic p, logic f);
    @(posedge clk);
    sys_rst <= 1'b1;
    por <= p;
    always_on_fuse <= f;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    por <= 1'b0;
  endtask
  // Restart, then count cycles until the reset request or the limit
  task automatic wait_pulse(int hi);
    @(posedge clk);
    restart_instruction <= 1'b1;
    idle(1);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (wdt_reset_pulse !== 1'b1 && n < hi);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {sys_rst, por, always_on_fuse, restart_instruction, reg_wr, reg_rd} = 6'h30;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    bad_count = 0;
    n_tests = 0;
    seed = 96653;
    rst(1'b1, 1'b0);
    rd(CTL, 8'h00, "ctl_reset");
    rd(CAU, 8'h00, "cause_por");
    rd(4'hf, 8'h00, "unmapped");
    rd(wdtta_pkg::OFS_IRQ_MASK, 8'h00, "mask_reset");
    bus(1'b1, wdtta_pkg::OFS_IRQ_MASK, 8'h03);
    bus(1'b1, CTL, 8'h08);
    bus(1'b1, CTL, 8'h00);
    rd(CTL, 8'h08, "ctl_refused");
    chk("irq_refused", 8'h01, 8'(irq));
    rd(wdtta_pkg::OFS_IRQ_STAT, 8'h02, "stat_refused");
    rd(wdtta_pkg::OFS_IRQ_STAT, 8'h00, "stat_clear");
    bus(1'b1, CTL, 8'h18);
    idle(4);
    rd(CTL, 8'h08, "unlock_expired");
    bus(1'b1, CTL, 8'h00);
    rd(CTL, 8'h08, "late_write");
    bus(1'b1, CTL, 8'h18);
    rd(CTL, ctl_val(1'b1, 1'b1, 3'h0), "unlock_open");
    bus(1'b1, CTL, 8'h00);
    rd(CTL, 8'h00, "disabled");
    wait_pulse(300);
    chk("quiet_off", 8'h00, 8'(wdt_reset_pulse));
    for (int t = 0; t < 8; t++) begin
      lim = ticks_for(t);
      bus(1'b1, CTL, 8'h18);
      bus(1'b1, CTL, (8'($random(seed)) & 8'he0) | 8'h08 | 8'(t));
      rd(CTL, ctl_val(1'b0, 1'b1, 3'(t)), "tsel_set");
      wait_pulse(1 + $unsigned($random(seed)) % (lim * 10));
      wait_pulse(lim * 25 + 30);
      chk("expiry", 8'h01, 8'(n >= lim * 25 && wdt_reset_pulse === 1'b1));
      rd(CAU, 8'h08, "cause_set");
      rst(1'b0, 1'b0);
      rd(CTL, 8'h00, "ctl_after");
    end
    bus(1'b1, CAU, 8'h00);
    rd(CAU, 8'h00, "cause_wr0");
    rst(1'b0, 1'b1);
    rd(CTL, 8'h08, "fuse_on");
    bus(1'b1, wdtta_pkg::OFS_IRQ_MASK, 8'h01);
    bus(1'b1, CTL, 8'h18);
    bus(1'b1, CTL, 8'h00);
    rd(CTL, 8'h08, "fuse_nodis");
    wait_pulse(TB * 25 + 30);
    chk("fuse_expiry", 8'h01, 8'(n >= TB * 25 && wdt_reset_pulse === 1'b1));
    idle(1);
    #1;
    chk("irq_timeout", 8'h01, 8'(irq));
    rd(wdtta_pkg::OFS_IRQ_STAT, 8'h01, "stat_timeout");
    rst(1'b1, 1'b0);
    rd(CAU, 8'h00, "cause_por2");
    complete_run();
  end
endmodule
